// [design/lqa_link_quality.sv]
// link quality threshold access register with sampling and monitor
//
// Summary of operation
// (RULE1) bits 15:14 ignore writes and read zero.
// (RULE2) writing sample bit one samples the selected parameter for reads.
// (RULE3) strobe loads data byte into threshold chosen by both selectors.
// (RULE4) strobe is a pulse and always reads zero.
// (RULE5) selector 0..5: equalizer, gain, wander, offset, control, variance.
// (RULE6) threshold selector zero picks low, one picks high.
// (RULE7) variance: selector 0 is bits 23:16, 1 is bits 31:24.
// (RULE8) data byte resets to 0x80, other fields to zero.
// (RULE9) with sample bit zero, written data targets the selected threshold.
// (RULE10) with sample bit zero, reads return the selected threshold.
// (RULE11) with sample bit one, reads return held sample until new sequence.
// (RULE12) threshold writes are refused while powered down.
// (RULE13) software sets selectors and data with or before the strobe.
// (RULE14) monitor runs only when enabled with a valid 100 Mb link.
// (RULE15) exceeding a threshold sets a warning flag cleared on read.
`timescale 1ns/1ps
module lqa_link_quality
  import lqa_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic [2:0]  register_page_select_i,
  input  wire logic [4:0]  reg_addr_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [15:0] reg_wdata_i,
  output logic      [15:0] reg_rdata_o,
  input  wire logic        power_down_i,
  input  wire logic        link_100_valid_i,
  input  wire logic [7:0]  equalizer_coefficient_i,
  input  wire logic [7:0]  gain_control_value_i,
  input  wire logic [7:0]  baseline_wander_value_i,
  input  wire logic [7:0]  freq_offset_value_i,
  input  wire logic [7:0]  freq_control_value_i,
  input  wire logic [15:0] variance_upper_i,
  output logic             monitor_active_o
);
  // ****************************************
  // register fields
  // ****************************************
  logic        sample_control_bit;
  logic [2:0]  parameter_selector;
  logic        threshold_selector;
  logic [7:0]  threshold_data_byte;
  logic [7:0]  sampled_value;
  logic        monitor_enable;
  logic [15:0] pdin_s1;
  logic [15:0] pdin_s2;
  logic [7:0]  pin_eq_s1, pin_eq_s2, pin_gn_s1, pin_gn_s2, pin_bw_s1, pin_bw_s2;
  logic [7:0]  pin_fo_s1, pin_fo_s2, pin_fc_s1, pin_fc_s2;
  logic [1:0]  ctl_s1, ctl_s2;

  // ****************************************
  // pin synchronisers
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_eq_s1 <= '0; pin_eq_s2 <= '0; pin_gn_s1 <= '0; pin_gn_s2 <= '0;
      pin_bw_s1 <= '0; pin_bw_s2 <= '0; pin_fo_s1 <= '0; pin_fo_s2 <= '0;
      pin_fc_s1 <= '0; pin_fc_s2 <= '0; pdin_s1 <= '0; pdin_s2 <= '0;
      ctl_s1 <= '0; ctl_s2 <= '0;
    end else begin
      pin_eq_s1 <= equalizer_coefficient_i; pin_eq_s2 <= pin_eq_s1;
      pin_gn_s1 <= gain_control_value_i;    pin_gn_s2 <= pin_gn_s1;
      pin_bw_s1 <= baseline_wander_value_i; pin_bw_s2 <= pin_bw_s1;
      pin_fo_s1 <= freq_offset_value_i;     pin_fo_s2 <= pin_fo_s1;
      pin_fc_s1 <= freq_control_value_i;    pin_fc_s2 <= pin_fc_s1;
      pdin_s1   <= variance_upper_i;        pdin_s2   <= pdin_s1;
      ctl_s1    <= {power_down_i, link_100_valid_i};
      ctl_s2    <= ctl_s1;
    end
  end

  wire powered_down = ctl_s2[1];
  wire link_valid   = ctl_s2[0];

  // ****************************************
  // address decode
  // ****************************************
  wire page_hit  = register_page_select_i == LQA_LINK_PAGE;
  wire sel_data  = page_hit && reg_addr_i == LQA_DATA_ACCESS_ADDR;
  wire sel_ctrl  = page_hit && reg_addr_i == LQA_MON_CTRL_ADDR;
  wire sel_ctrl2 = page_hit && reg_addr_i == LQA_MON_CTRL2_ADDR;
  wire wr_data   = reg_wr_i && sel_data;
  wire wr_ctrl   = reg_wr_i && sel_ctrl;
  wire new_sample = wr_data && reg_wdata_i[LQA_SAMPLE_BIT]; // RULE2 RULE11

  // strobe uses the selectors and data of the same write
  wire [2:0] wr_psel = reg_wdata_i[LQA_PSEL_MSB:LQA_PSEL_LSB];
  wire       wr_tsel = reg_wdata_i[LQA_TSEL_BIT];
  wire       psel_ok = wr_psel <= LQA_P_VAR; // RULE5
  wire thr_wr_en = wr_data && reg_wdata_i[LQA_WSTROBE_BIT] && psel_ok
                   && !powered_down; // RULE3 RULE12 RULE13
  // index = {param, low/high}; variance lands on 10 (low) and 11 (high), both compared against bits 31:24
  wire [3:0] wr_idx = {wr_psel, wr_tsel}; // RULE6 RULE7
  wire [3:0] rd_idx = {parameter_selector, threshold_selector}; // RULE6 RULE10

  // ****************************************
  // register write
  // ****************************************
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sample_control_bit  <= LQA_DATA_ACCESS_RESET[LQA_SAMPLE_BIT]; // RULE8
      parameter_selector  <= LQA_DATA_ACCESS_RESET[LQA_PSEL_MSB:LQA_PSEL_LSB];
      threshold_selector  <= LQA_DATA_ACCESS_RESET[LQA_TSEL_BIT];
      threshold_data_byte <= LQA_THR_DATA_RESET; // RULE8
      monitor_enable      <= 1'b0;
    end else begin
      if (wr_data) begin
        // bits 15:14 and the strobe are not stored
        sample_control_bit  <= reg_wdata_i[LQA_SAMPLE_BIT]; // RULE1 RULE4
        parameter_selector  <= wr_psel;
        threshold_selector  <= wr_tsel;
        threshold_data_byte <= reg_wdata_i[7:0]; // RULE9
      end
      if (wr_ctrl) begin
        monitor_enable <= reg_wdata_i[LQA_MON_EN_BIT];
      end
    end
  end

  // ****************************************
  // parameter sampling
  // ****************************************
  logic [7:0] param_mux;
  wire [LQA_NUM_PARAMS*8-1:0] param_flat =
    {pdin_s2[15:8], pin_fc_s2, pin_fo_s2, pin_bw_s2, pin_gn_s2, pin_eq_s2};
  always_comb begin
    case (lqa_param_t'(wr_psel)) // RULE5
      LQA_P_EQ:   param_mux = pin_eq_s2;
      LQA_P_GAIN: param_mux = pin_gn_s2;
      LQA_P_BLW:  param_mux = pin_bw_s2;
      LQA_P_FOFS: param_mux = pin_fo_s2;
      LQA_P_FCTL: param_mux = pin_fc_s2;
      LQA_P_VAR:  param_mux = wr_tsel ? pdin_s2[15:8] : pdin_s2[7:0]; // RULE7
      default:    param_mux = 8'h00;
    endcase
  end

  // held until next sampling write
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sampled_value <= 8'h00;
    end else if (new_sample) begin
      sampled_value <= param_mux; // RULE2 RULE11
    end
  end

  // ****************************************
  // threshold bank and monitor
  // ****************************************
  logic [7:0]                 thr_rd;
  logic [LQA_NUM_THR*8-1:0]   thr_flat;
  logic [LQA_NUM_THR-1:0]     warn;

  lqa_thr_bank u_bank (
    .clk_sys_i  (clk_sys_i),
    .rst_n_i    (rst_n_i),
    .wr_en_i    (thr_wr_en),
    .wr_idx_i   (wr_idx),
    .wr_data_i  (reg_wdata_i[7:0]),
    .rd_idx_i   (rd_idx),
    .rd_data_o  (thr_rd),
    .thr_flat_o (thr_flat)
  );

  wire mon_active = monitor_enable && link_valid; // RULE14
  wire rd_ctrl    = reg_rd_i && sel_ctrl;
  wire rd_ctrl2   = reg_rd_i && sel_ctrl2;

  lqa_monitor u_mon (
    .clk_sys_i    (clk_sys_i),
    .rst_n_i      (rst_n_i),
    .active_i     (mon_active),
    .param_flat_i (param_flat),
    .thr_flat_i   (thr_flat),
    .clr_i        (rd_ctrl || rd_ctrl2),
    .warn_o       (warn)
  );

  // ****************************************
  // read mux
  // ****************************************
  wire [7:0]  data_rd = sample_control_bit ? sampled_value : thr_rd; // RULE10 RULE11
  wire [15:0] data_word = {2'b00, sample_control_bit, 1'b0, parameter_selector,
                           threshold_selector, data_rd}; // RULE1 RULE4
  wire [15:0] ctrl_word = {monitor_enable, 5'h00, warn[9:0]}; // RULE15
  wire [15:0] ctrl2_word = {14'h0000, warn[11], 1'b0};

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o      <= 16'h0000;
      monitor_active_o <= 1'b0;
    end else begin
      monitor_active_o <= mon_active;
      if (sel_data) begin
        reg_rdata_o <= data_word;
      end else if (sel_ctrl) begin
        reg_rdata_o <= ctrl_word;
      end else if (sel_ctrl2) begin
        reg_rdata_o <= ctrl2_word;
      end else begin
        reg_rdata_o <= 16'h0000;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic [3:0] wr_idx_q;
  chk_strobe_reads_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    sel_data |=> reg_rdata_o[LQA_WSTROBE_BIT] == 1'b0) // RULE4
    else $error("strobe bit read as one");
  chk_reserved_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    sel_data |=> reg_rdata_o[15:14] == 2'b00) // RULE1
    else $error("reserved bits read nonzero");
  chk_pd_no_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (wr_data && reg_wdata_i[LQA_WSTROBE_BIT] && powered_down) |=> $stable(thr_flat)) // RULE12
    else $error("threshold write while powered down");
  chk_thr_written: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    thr_wr_en |=> thr_flat[wr_idx_q*8 +: 8] == $past(reg_wdata_i[7:0])) // RULE3
    else $error("threshold not loaded");
  chk_sample_hold: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !new_sample |=> $stable(sampled_value)) // RULE11
    else $error("sample changed without new sequence");
  chk_sample_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (sel_data && sample_control_bit) |=> reg_rdata_o[7:0] == $past(sampled_value)) // RULE11
    else $error("sampled value not returned");
  chk_thr_read: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    (sel_data && !sample_control_bit) |=> reg_rdata_o[7:0] == $past(thr_rd)) // RULE10
    else $error("threshold value not returned");
  chk_mon_gate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    !(monitor_enable && link_valid) |=> !monitor_active_o) // RULE14
    else $error("monitor active without enable and link");
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_idx_q <= 4'h0;
    end else begin
      wr_idx_q <= wr_idx;
    end
  end
endmodule // lqa_link_quality

// [design/lqa_monitor.sv]
// compare of adapted parameters against thresholds, sticky clear-on-read warnings
`timescale 1ns/1ps
module lqa_monitor
  import lqa_pkg::*;
(
  input  wire logic                     clk_sys_i,
  input  wire logic                     rst_n_i,
  input  wire logic                     active_i,
  input  wire logic [LQA_NUM_PARAMS*8-1:0] param_flat_i,
  input  wire logic [LQA_NUM_THR*8-1:0] thr_flat_i,
  input  wire logic                     clr_i,
  output logic      [LQA_NUM_THR-1:0]   warn_o
);
  logic [LQA_NUM_THR-1:0] hit;
  genvar g;
  generate
    for (g = 0; g < LQA_NUM_PARAMS; g++) begin : g_cmp
      assign hit[2*g]   = param_flat_i[g*8 +: 8] < thr_flat_i[(2*g)*8 +: 8];
      assign hit[2*g+1] = param_flat_i[g*8 +: 8] > thr_flat_i[(2*g+1)*8 +: 8];
    end
  endgenerate
  // set wins over the read clear
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      warn_o <= '0;
    end else begin
      warn_o <= (clr_i ? '0 : warn_o) | (active_i ? hit : '0); // RULE14 RULE15
    end
  end
endmodule // lqa_monitor

// [design/lqa_pkg.sv]
// package: register map, field layout and reset values of the link quality data access block
package lqa_pkg;
  localparam logic [4:0]  LQA_DATA_ACCESS_ADDR  = 5'h1e;
  localparam logic [4:0]  LQA_MON_CTRL_ADDR     = 5'h1d;
  localparam logic [4:0]  LQA_MON_CTRL2_ADDR    = 5'h1f;
  localparam logic [2:0]  LQA_LINK_PAGE         = 3'h2;
  localparam int          LQA_SAMPLE_BIT        = 13;
  localparam int          LQA_WSTROBE_BIT       = 12;
  localparam int          LQA_PSEL_MSB          = 11;
  localparam int          LQA_PSEL_LSB          = 9;
  localparam int          LQA_TSEL_BIT          = 8;
  localparam int          LQA_MON_EN_BIT        = 15;
  localparam int          LQA_VAR_HI_BIT        = 1;
  localparam logic [15:0] LQA_DATA_ACCESS_RESET = 16'h0080;
  localparam logic [7:0]  LQA_THR_DATA_RESET    = 8'h80;
  // low limits reset to the data field value, so the first read shows it
  localparam logic [7:0]  LQA_THR_LOW_RESET     = 8'h80;
  localparam logic [7:0]  LQA_THR_HIGH_RESET    = 8'hff;
  localparam int          LQA_NUM_PARAMS        = 6;
  localparam int          LQA_NUM_THR           = 12;
  localparam int          LQA_SAMPLE_CYCLES     = 2;
  typedef enum logic [2:0] {
    LQA_P_EQ   = 3'h0,
    LQA_P_GAIN = 3'h1,
    LQA_P_BLW  = 3'h2,
    LQA_P_FOFS = 3'h3,
    LQA_P_FCTL = 3'h4,
    LQA_P_VAR  = 3'h5
  } lqa_param_t;
endpackage

// [design/lqa_thr_bank.sv]
// threshold storage: twelve 8-bit low/high limits addressed by parameter and selector
`timescale 1ns/1ps
module lqa_thr_bank
  import lqa_pkg::*;
(
  input  wire logic                       clk_sys_i,
  input  wire logic                       rst_n_i,
  input  wire logic                       wr_en_i,
  input  wire logic [3:0]                 wr_idx_i,
  input  wire logic [7:0]                 wr_data_i,
  input  wire logic [3:0]                 rd_idx_i,
  output logic      [7:0]                 rd_data_o,
  output logic      [LQA_NUM_THR*8-1:0]   thr_flat_o
);
  logic [7:0] thr_mem [LQA_NUM_THR];
  genvar g;
  generate
    for (g = 0; g < LQA_NUM_THR; g++) begin : g_thr
      // even index = low threshold, odd index = high threshold
      always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          thr_mem[g] <= (g % 2 == 1) ? LQA_THR_HIGH_RESET : LQA_THR_LOW_RESET;
        end else if (wr_en_i && wr_idx_i == 4'(g)) begin
          thr_mem[g] <= wr_data_i; // RULE3
        end
      end
      assign thr_flat_o[g*8 +: 8] = thr_mem[g];
    end
  endgenerate
  assign rd_data_o = (rd_idx_i < 4'(LQA_NUM_THR)) ? thr_mem[rd_idx_i] : 8'h00;
endmodule // lqa_thr_bank

// [verif/link_quality_threshold_access_test.sv]
// self-checking bench for the link quality data access register
`timescale 1ns/1ps
module link_quality_threshold_access_test
  import lqa_pkg::*;
;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i   = 1'b0;
  logic [2:0]  page;
  logic [4:0]  addr;
  logic        wr;
  logic        rd;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        power_down_i     = 1'b0;
  logic        link_100_valid_i = 1'b0;
  logic [7:0]  prm [5]          = '{8'h11, 8'h22, 8'h44, 8'h88, 8'h5a};
  logic [15:0] var_hi           = 16'hc3b4;
  logic        monitor_active_o;
  logic [15:0] seen;
  logic [7:0]  tv;
  int          n_fail = 0;
  int          checks = 0;
  int          cycles = 0;

  always #5 clk_sys_i = ~clk_sys_i;

  lqa_host_model lqa_host_model_inst (
    .clk_sys_i              (clk_sys_i),
    .reg_rdata_i            (rdata),
    .register_page_select_o (page),
    .reg_addr_o             (addr),
    .reg_wr_o               (wr),
    .reg_rd_o               (rd),
    .reg_wdata_o            (wdata)
  );

  lqa_link_quality lqa_link_quality_inst (
    .clk_sys_i               (clk_sys_i),
    .rst_n_i                 (rst_n_i),
    .register_page_select_i  (page),
    .reg_addr_i              (addr),
    .reg_wr_i                (wr),
    .reg_rd_i                (rd),
    .reg_wdata_i             (wdata),
    .reg_rdata_o             (rdata),
    .power_down_i            (power_down_i),
    .link_100_valid_i        (link_100_valid_i),
    .equalizer_coefficient_i (prm[0]),
    .gain_control_value_i    (prm[1]),
    .baseline_wander_value_i (prm[2]),
    .freq_offset_value_i     (prm[3]),
    .freq_control_value_i    (prm[4]),
    .variance_upper_i        (var_hi),
    .monitor_active_o        (monitor_active_o)
  );

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: read %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // select a threshold without strobe, then read its contents back
  task automatic chk_thr(input logic [2:0] p, input logic t, input logic [7:0] v);
    lqa_host_model_inst.wr_reg(LQA_DATA_ACCESS_ADDR, {4'h0, p, t, 8'h00});
    lqa_host_model_inst.rd_reg(LQA_DATA_ACCESS_ADDR, seen);
    check(seen, {4'h0, p, t, v});
  endtask

  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      end_of_test();
    end
  end

  // ****************************************
  // tests
  // ****************************************
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    lqa_host_model_inst.rd_reg(LQA_DATA_ACCESS_ADDR, seen);
    check(seen, LQA_DATA_ACCESS_RESET);
    for (int i = 0; i < LQA_NUM_THR; i++) begin
      chk_thr(i[3:1], i[0], i[0] ? LQA_THR_HIGH_RESET : LQA_THR_LOW_RESET);
    end
    $display("test reset done");

    for (int i = 0; i < LQA_NUM_THR; i++) begin
      tv = 8'h30 + i[7:0];
      lqa_host_model_inst.wr_reg(LQA_DATA_ACCESS_ADDR, {2'b11, 2'b01, i[3:1], i[0], tv});
      lqa_host_model_inst.rd_reg(LQA_DATA_ACCESS_ADDR, seen);
      check(seen, {4'h0, i[3:1], i[0], tv});
    end
    for (int i = 0; i < LQA_NUM_THR; i++) begin
      chk_thr(i[3:1], i[0], 8'h30 + i[7:0]);
    end
    $display("test threshold write done");

    for (int i = 0; i < LQA_NUM_THR; i++) begin
      if (i[3:1] < 3'h5 && i[0])
        continue;
      tv = (i[3:1] < 3'h5) ? prm[i[3:1]] : (i[0] ? var_hi[15:8] : var_hi[7:0]);
      lqa_host_model_inst.wr_reg(LQA_DATA_ACCESS_ADDR, {4'b0010, i[3:1], i[0], 8'h00});
      lqa_host_model_inst.rd_reg(LQA_DATA_ACCESS_ADDR, seen);
      check(seen, {4'b0010, i[3:1], i[0], tv});
    end
    @(posedge clk_sys_i);
    var_hi <= 16'h0f0f;
    repeat (4) @(posedge clk_sys_i);
    lqa_host_model_inst.rd_reg(LQA_DATA_ACCESS_ADDR, seen);
    check(seen, {4'b0010, 3'h5, 1'b1, 8'hc3});
    $display("test sampling done");

    @(posedge clk_sys_i);
    power_down_i <= 1'b1;
    repeat (4) @(posedge clk_sys_i);
    lqa_host_model_inst.wr_reg(LQA_DATA_ACCESS_ADDR, {4'b0001, 3'h0, 1'b0, 8'h77});
    @(posedge clk_sys_i);
    power_down_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    chk_thr(3'h0, 1'b0, 8'h30);
    lqa_host_model_inst.set_page(3'h0);
    lqa_host_model_inst.wr_reg(LQA_DATA_ACCESS_ADDR, {4'b0001, 3'h0, 1'b0, 8'h99});
    lqa_host_model_inst.rd_reg(LQA_DATA_ACCESS_ADDR, seen);
    check(seen, 16'h0000);
    lqa_host_model_inst.set_page(LQA_LINK_PAGE);
    chk_thr(3'h0, 1'b0, 8'h30);
    $display("test power down done");

    lqa_host_model_inst.rd_reg(5'h05, seen);
    check(seen, 16'h0000);
    lqa_host_model_inst.wr_reg(LQA_MON_CTRL_ADDR, 16'h8000);
    repeat (4) @(posedge clk_sys_i);
    check({15'h0000, monitor_active_o}, 16'h0000);
    link_100_valid_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    check({15'h0000, monitor_active_o}, 16'h0001);
    lqa_host_model_inst.rd_reg(LQA_MON_CTRL_ADDR, seen);
    check(seen, 16'h82a5);
    lqa_host_model_inst.rd_reg(LQA_MON_CTRL2_ADDR, seen);
    check(seen, 16'h0000);
    $display("test unmapped and monitor done");
    end_of_test();
  end
endmodule // link_quality_threshold_access_test

// [verif/lqa_host_model.sv]
// management host model: page-2 register reads and writes on the block's access protocol
`timescale 1ns/1ps
module lqa_host_model
  import lqa_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic [15:0] reg_rdata_i,
  output logic      [2:0]  register_page_select_o,
  output logic      [4:0]  reg_addr_o,
  output logic             reg_wr_o,
  output logic             reg_rd_o,
  output logic      [15:0] reg_wdata_o
);
  // ****************************************
  // bus cycles
  // ****************************************
  initial begin
    register_page_select_o = LQA_LINK_PAGE;
    reg_addr_o             = 5'h00;
    reg_wr_o               = 1'b0;
    reg_rd_o               = 1'b0;
    reg_wdata_o            = 16'h0000;
  end

  // selectors and data byte travel in the strobe write itself
  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk_sys_i);
    reg_addr_o  <= a;
    reg_wdata_o <= d;
    reg_wr_o    <= 1'b1;
    @(posedge clk_sys_i);
    reg_wr_o    <= 1'b0;
    reg_wdata_o <= ~d;
  endtask

  // read data lands one cycle after the address, taken at the next edge
  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk_sys_i);
    reg_addr_o <= a;
    reg_rd_o   <= 1'b1;
    @(posedge clk_sys_i);
    reg_rd_o   <= 1'b0;
    @(posedge clk_sys_i);
    d = reg_rdata_i;
  endtask

  // switch the register page between accesses
  task automatic set_page(input logic [2:0] p);
    @(posedge clk_sys_i);
    register_page_select_o <= p;
  endtask
endmodule // lqa_host_model
